// ==== cidt_defs.svh ====
`ifndef CIDT_DEFS_SVH
`define CIDT_DEFS_SVH
// Behaviour
// - a single word is 24 bits; its leading 8-bit field is the opcode.
// - only three opcodes span two program words; all others are single word.
// - two-word instructions carry 48 bits; second word's upper 8 bits are zero.
// - a lone second word reached by itself executes as a no-operation.
// - a single-word instruction normally completes in one instruction cycle.
// - true condition or program counter change adds one no-operation cycle.
// - jumps, computed or indirect branches, table accesses, returns take two or three cycles.
// - taken skip costs two cycles over one word, three over two words.
// - every double-word instruction, double-word moves included, takes two cycles.
// - instructions sort into word/byte, bit, literal and control classes.
// - three-operand forms: unmodified first source, second source and result may be modified.
// - file-register forms name a memory address; result goes there or accumulator.
// - bit forms name a register or memory; bit from literal or register.
// - literal moves load a literal into a working register or memory location.
// - literal arithmetic uses unmodified source; separate result only when flagged different.
// - control forms carry a program address or a table transfer mode.

// word layout
`define CIDT_WORD_W 24
`define CIDT_OP_HI 23
`define CIDT_OP_LO 16
`define CIDT_OPD_W 16
`define CIDT_ZERO_OP 8'h00

// opcodes that the sequencer must recognise
`define CIDT_OP_JUMP_ALWAYS 8'h01
`define CIDT_OP_COMPUTED 8'h02
`define CIDT_OP_IND_CALL 8'h03
`define CIDT_OP_IND_JUMP 8'h04
`define CIDT_OP_TBL_READ 8'h05
`define CIDT_OP_TBL_WRITE 8'h06
`define CIDT_OP_RETURN 8'h07
`define CIDT_OP_INT_RETURN 8'h08
`define CIDT_OP_COND_BRANCH 8'h09
`define CIDT_OP_CALL_LONG 8'h0a
`define CIDT_OP_GOTO_LONG 8'h0b
`define CIDT_OP_MOVE_LONG 8'h0c
`define CIDT_OP_SKIP 8'h0d
`define CIDT_OP_DMOVE 8'h7e

// cycle counts per instruction
`define CIDT_CYC_BRANCH 2
`define CIDT_CYC_TABLE 2
`define CIDT_CYC_RETURN 3
`define CIDT_CYC_DOUBLE 2
`define CIDT_CYC_TAKEN 2
`endif

// ==== cidt_pkg.sv ====
package cidt_pkg;
	// operand classes, from opcode bits 7:6
	typedef enum logic [1:0] {
		CIDT_CLS_CTRL = 2'b00,
		CIDT_CLS_WORD = 2'b01,
		CIDT_CLS_BIT = 2'b10,
		CIDT_CLS_LIT = 2'b11
	} cidt_class_t;

	// sequencer states, one-hot
	typedef enum logic [5:0] {
		CIDT_ST_FETCH = 6'b00_0001,
		CIDT_ST_SECOND = 6'b00_0010,
		CIDT_ST_ISSUE = 6'b00_0100,
		CIDT_ST_BUBBLE = 6'b00_1000,
		CIDT_ST_SKIP = 6'b01_0000,
		CIDT_ST_SKIP2 = 6'b10_0000
	} cidt_state_t;

	// decoded instruction handed to the execute datapath
	typedef struct packed {
		logic [7:0] opcode;
		cidt_class_t op_class;
		logic byte_mode;
		logic two_word;
		logic [3:0] first_source_register;
		logic [3:0] second_source_register;
		logic [1:0] source_mode;
		logic [3:0] result_register;
		logic [1:0] result_mode;
		logic [12:0] file_addr;
		logic to_file;
		logic to_default_accumulator;
		logic [3:0] bit_number;
		logic bit_from_register;
		logic [15:0] literal;
		logic [22:0] prog_addr;
		logic [1:0] table_mode;
	} cidt_dec_t;
endpackage : cidt_pkg

// ==== cidt_decoder.sv ====
`timescale 1ns/1ps
`include "cidt_defs.svh"

module cidt_decoder #(
	parameter int unsigned CYC_BRANCH = `CIDT_CYC_BRANCH,
	parameter int unsigned CYC_TABLE = `CIDT_CYC_TABLE,
	parameter int unsigned CYC_RETURN = `CIDT_CYC_RETURN
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// program memory fetch side
	input wire logic fetch_valid,
	input wire logic [23:0] fetch_word,
	output logic fetch_ready,
	output logic fetch_flush,
	// execute datapath side
	output cidt_pkg::cidt_dec_t dec,
	output logic issue,
	output logic bubble,
	input wire logic exec_taken
);

	// the bubble counter is two bits wide, so no count may exceed three cycles
	generate
		if (CYC_BRANCH < 2 || CYC_BRANCH > 3 || CYC_TABLE < 2 || CYC_TABLE > 3
			|| CYC_RETURN < 2 || CYC_RETURN > 3)
		begin : g_bad_cycles
			$error("cidt_decoder: multi-cycle counts must be 2 or 3");
		end
	endgenerate

	localparam logic [1:0] EXTRA_BRANCH = 2'(CYC_BRANCH - 1);
	localparam logic [1:0] EXTRA_TABLE = 2'(CYC_TABLE - 1);
	localparam logic [1:0] EXTRA_RETURN = 2'(CYC_RETURN - 1);
	localparam logic [1:0] EXTRA_DOUBLE = 2'(`CIDT_CYC_DOUBLE - 1);
	localparam logic [1:0] EXTRA_TAKEN = 2'(`CIDT_CYC_TAKEN - 1);

	cidt_pkg::cidt_state_t state_q, state_d;
	cidt_pkg::cidt_dec_t dec_q, dec_d;
	logic [23:0] word1_q;
	logic [1:0] extra_q, extra_d;
	logic cond_q, cond_d;
	logic skip_q, skip_d;
	logic redirect_q, redirect_d;
	logic [1:0] cnt_q, cnt_d;
	logic ready_q, ready_d;
	logic flush_q, flush_d;
	logic issue_q, issue_d;
	logic bubble_q, bubble_d;

	// fields of the incoming word
	wire logic take = fetch_valid & ready_q;
	wire logic [7:0] in_op = fetch_word[`CIDT_OP_HI:`CIDT_OP_LO];
	wire logic in_two_word = (in_op == `CIDT_OP_CALL_LONG) | (in_op == `CIDT_OP_GOTO_LONG)
		| (in_op == `CIDT_OP_MOVE_LONG);

	// instruction under decode: first word held while the second one arrives
	wire logic in_second = state_q == cidt_pkg::CIDT_ST_SECOND;
	wire logic [23:0] w1 = in_second ? word1_q : fetch_word;
	wire logic [7:0] op = w1[`CIDT_OP_HI:`CIDT_OP_LO];
	wire logic [15:0] opd = w1[15:0];
	// second word contributes only its low bits; its top byte is zero
	wire logic [15:0] ext = in_second ? fetch_word[15:0] : 16'h0000;
	wire cidt_pkg::cidt_class_t cls = cidt_pkg::cidt_class_t'(op[7:6]);

	// attributes that steer the cycle count
	wire logic is_branch = (op == `CIDT_OP_JUMP_ALWAYS) | (op == `CIDT_OP_COMPUTED)
		| (op == `CIDT_OP_IND_CALL) | (op == `CIDT_OP_IND_JUMP);
	wire logic is_table = (op == `CIDT_OP_TBL_READ) | (op == `CIDT_OP_TBL_WRITE);
	wire logic is_return = (op == `CIDT_OP_RETURN) | (op == `CIDT_OP_INT_RETURN);
	wire logic is_long_pc = (op == `CIDT_OP_CALL_LONG) | (op == `CIDT_OP_GOTO_LONG);
	wire logic is_double = in_second | (op == `CIDT_OP_DMOVE);
	wire logic is_cond = op == `CIDT_OP_COND_BRANCH;
	wire logic is_skip = op == `CIDT_OP_SKIP;

	// fixed extra cycles; conditional ones are added at issue
	wire logic [1:0] fixed_extra = is_branch ? EXTRA_BRANCH :
		is_table ? EXTRA_TABLE :
		is_return ? EXTRA_RETURN :
		is_double ? EXTRA_DOUBLE : 2'b00;

	// operand field extraction per class
	always_comb
	begin
		dec_d = '0;
		dec_d.opcode = op;
		dec_d.op_class = cls;
		dec_d.byte_mode = op[0];
		dec_d.two_word = in_second;
		case (cls)
			cidt_pkg::CIDT_CLS_WORD:
			begin
				if (op[1])
				begin
					// file form, result to memory or accumulator
					dec_d.file_addr = opd[12:0];
					dec_d.to_default_accumulator = opd[13];
					dec_d.to_file = ~opd[13];
					dec_d.byte_mode = opd[14];
				end
				else
				begin
					// first source has no address modifier
					dec_d.first_source_register = opd[15:12];
					dec_d.second_source_register = opd[3:0];
					dec_d.source_mode = opd[5:4];
					dec_d.result_register = opd[9:6];
					dec_d.result_mode = opd[11:10];
				end
			end
			cidt_pkg::CIDT_CLS_BIT:
			begin
				// target register or memory, bit by literal or register
				dec_d.bit_number = opd[3:0];
				if (op[1])
				begin
					dec_d.to_file = 1'b1;
					dec_d.file_addr = {1'b0, opd[15:4]};
				end
				else
				begin
					dec_d.bit_from_register = opd[4];
					dec_d.first_source_register = opd[3:0];
					dec_d.second_source_register = opd[8:5];
					dec_d.source_mode = opd[10:9];
				end
			end
			cidt_pkg::CIDT_CLS_LIT:
			begin
				if (op[5])
				begin
					// result register only when flagged separate
					dec_d.first_source_register = opd[3:0];
					dec_d.literal = {11'h000, opd[8:4]};
					dec_d.result_register = opd[9] ? opd[13:10] : opd[3:0];
					dec_d.result_mode = opd[9] ? opd[15:14] : 2'b00;
				end
				else if (op[1])
				begin
					dec_d.to_file = 1'b1;
					dec_d.literal = {8'h00, opd[7:0]};
					dec_d.file_addr = {5'h00, opd[15:8]};
				end
				else
				begin
					dec_d.result_register = opd[3:0];
					dec_d.literal = {4'h0, opd[15:4]};
				end
			end
			default:
			begin
				dec_d.table_mode = opd[1:0];
				dec_d.prog_addr = {ext[6:0], opd};
				if (op == `CIDT_OP_MOVE_LONG)
				begin
					dec_d.result_register = opd[3:0];
					dec_d.literal = {ext[7:0], opd[11:4]};
				end
			end
		endcase
	end

	// sequencer: fetch, second word, issue slot, no-operation slots, skipped words
	always_comb
	begin
		state_d = state_q;
		extra_d = extra_q;
		cond_d = cond_q;
		skip_d = skip_q;
		redirect_d = redirect_q;
		cnt_d = cnt_q;
		ready_d = ready_q;
		flush_d = 1'b0;
		issue_d = 1'b0;
		bubble_d = 1'b0;
		case (state_q)
			cidt_pkg::CIDT_ST_FETCH:
			begin
				if (take && in_two_word)
				begin
					state_d = cidt_pkg::CIDT_ST_SECOND;
				end
				else if (take)
				begin
					// a lone zero-topped word decodes as opcode zero, a no-operation
					// one issue slot unless extras apply
					state_d = cidt_pkg::CIDT_ST_ISSUE;
					ready_d = 1'b0;
					issue_d = 1'b1;
					extra_d = fixed_extra;
					cond_d = is_cond;
					skip_d = is_skip;
					redirect_d = is_branch | is_return;
				end
			end
			cidt_pkg::CIDT_ST_SECOND:
			begin
				if (take)
				begin
					state_d = cidt_pkg::CIDT_ST_ISSUE;
					ready_d = 1'b0;
					issue_d = 1'b1;
					extra_d = fixed_extra;
					cond_d = 1'b0;
					skip_d = 1'b0;
					redirect_d = is_long_pc;
				end
			end
			cidt_pkg::CIDT_ST_ISSUE:
			begin
				if (skip_q && exec_taken)
				begin
					// skipped words are consumed and dropped
					state_d = cidt_pkg::CIDT_ST_SKIP;
					ready_d = 1'b1;
				end
				else if (cond_q && exec_taken)
				begin
					// taken condition adds a no-operation cycle
					state_d = cidt_pkg::CIDT_ST_BUBBLE;
					cnt_d = EXTRA_TAKEN - 2'd1;
					bubble_d = 1'b1;
					flush_d = 1'b1;
				end
				else if (extra_q != 2'b00)
				begin
					state_d = cidt_pkg::CIDT_ST_BUBBLE;
					cnt_d = extra_q - 2'd1;
					bubble_d = 1'b1;
					flush_d = redirect_q;
				end
				else
				begin
					state_d = cidt_pkg::CIDT_ST_FETCH;
					ready_d = 1'b1;
				end
			end
			cidt_pkg::CIDT_ST_BUBBLE:
			begin
				if (cnt_q != 2'b00)
				begin
					cnt_d = cnt_q - 2'd1;
					bubble_d = 1'b1;
				end
				else
				begin
					state_d = cidt_pkg::CIDT_ST_FETCH;
					ready_d = 1'b1;
				end
			end
			cidt_pkg::CIDT_ST_SKIP:
			begin
				if (take)
				begin
					bubble_d = 1'b1;
					state_d = in_two_word ? cidt_pkg::CIDT_ST_SKIP2 : cidt_pkg::CIDT_ST_FETCH;
				end
			end
			cidt_pkg::CIDT_ST_SKIP2:
			begin
				if (take)
				begin
					// second word of a skipped pair
					bubble_d = 1'b1;
					state_d = cidt_pkg::CIDT_ST_FETCH;
				end
			end
			default:
			begin
				state_d = cidt_pkg::CIDT_ST_FETCH;
				ready_d = 1'b1;
			end
		endcase
	end

	// state and handshake registers
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			state_q <= cidt_pkg::CIDT_ST_FETCH;
			ready_q <= 1'b1;
			extra_q <= 2'b00;
			cond_q <= 1'b0;
			skip_q <= 1'b0;
			redirect_q <= 1'b0;
			cnt_q <= 2'b00;
		end
		else
		begin
			state_q <= state_d;
			ready_q <= ready_d;
			extra_q <= extra_d;
			cond_q <= cond_d;
			skip_q <= skip_d;
			redirect_q <= redirect_d;
			cnt_q <= cnt_d;
		end
	end

	// pulses toward execute and fetch
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			flush_q <= 1'b0;
			issue_q <= 1'b0;
			bubble_q <= 1'b0;
		end
		else
		begin
			flush_q <= flush_d;
			issue_q <= issue_d;
			bubble_q <= bubble_d;
		end
	end

	// first word held across the second fetch; decode latched at issue only
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			word1_q <= 24'h00_0000;
			dec_q <= '0;
		end
		else
		begin
			if (take && state_q == cidt_pkg::CIDT_ST_FETCH)
			begin
				word1_q <= fetch_word;
			end
			if (issue_d)
			begin
				dec_q <= dec_d;
			end
		end
	end

	// outputs straight from flops
	assign fetch_ready = ready_q;
	assign fetch_flush = flush_q;
	assign issue = issue_q;
	assign bubble = bubble_q;
	assign dec = dec_q;

endmodule : cidt_decoder

// ==== cidt_decoder_props.sv ====
`timescale 1ns/1ps
module cidt_decoder_chk #(
	parameter int unsigned CYC_BRANCH = 2,
	parameter int unsigned CYC_TABLE = 2,
	parameter int unsigned CYC_RETURN = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// fetch side
	input wire logic fetch_valid,
	input wire logic [23:0] fetch_word,
	input wire logic fetch_ready,
	input wire logic fetch_flush,
	// execute side
	input wire cidt_pkg::cidt_dec_t dec,
	input wire logic issue,
	input wire logic bubble,
	input wire logic exec_taken
);
	logic [7:0] op;
	logic [3:0] cnt_q, cnt_d, exp_q, exp_d;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// bubble tally since the last issue; f marks a taken skip, whose cost depends on the skipped word
	assign op = dec.opcode;
	assign cnt_d = issue ? 4'h0 : cnt_q + {3'h0, bubble};
	assign exp_d = (op inside {[8'h01:8'h04]}) ? 4'(CYC_BRANCH - 1) :
		(op inside {8'h05, 8'h06}) ? 4'(CYC_TABLE - 1) :
		(op inside {8'h07, 8'h08}) ? 4'(CYC_RETURN - 1) :
		(op inside {[8'h0a:8'h0c], 8'h7e}) ? 4'h1 :
		(op == 8'h09) ? {3'h0, exec_taken} :
		(op == 8'h0d && exec_taken) ? 4'hf : 4'h0;

	// tally registers
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			cnt_q <= 4'h0;
			exp_q <= 4'h0;
		end
		else
		begin
			cnt_q <= cnt_d;
			if (issue)
				exp_q <= exp_d;
		end
	end

	// added cycle that also redirects fetch, and a quiet cycle
	sequence s_pc_bubble;
		bubble && fetch_flush;
	endsequence
	sequence s_quiet;
		!bubble && !fetch_flush;
	endsequence

	a_cycle_count: assert property (issue && exp_q != 4'hf |-> cnt_q == exp_q)
		else $error("wrong number of added cycles");
	a_skip_length: assert property (issue && exp_q == 4'hf |-> cnt_q inside {4'h1, 4'h2})
		else $error("taken skip cost out of range");
	a_plain_single: assert property (issue && op[7:6] != 2'b00 && op != 8'h7e |=> s_quiet)
		else $error("single word instruction took extra cycle");
	a_jump_flush: assert property (issue && op inside {[8'h01:8'h04]} |=> s_pc_bubble)
		else $error("jump without flushed bubble");
	a_cond_taken: assert property (issue && op == 8'h09 && exec_taken |=> s_pc_bubble ##1 s_quiet)
		else $error("taken branch not exactly one bubble");
	a_skip_fill: assert property (issue && op == 8'h0d && exec_taken
		|=> (!issue && !fetch_flush) throughout (##[0:60] bubble))
		else $error("skipped word not consumed as bubble");
	a_lone_nop: assert property (issue && op == 8'h00 |=> s_quiet)
		else $error("lone second word not a one cycle nop");
	a_double_move: assert property (issue && op == 8'h7e |=> bubble && !fetch_flush ##1 !bubble)
		else $error("double move not two cycles");
	a_class_sort: assert property (issue |-> dec.op_class == cidt_pkg::cidt_class_t'(op[7:6]))
		else $error("operand class mismatch");
	a_pair_flag: assert property (issue |-> dec.two_word == (op inside {[8'h0a:8'h0c]}))
		else $error("two word flag mismatch");
	a_flush_bubble: assert property (fetch_flush |-> bubble)
		else $error("flush outside a bubble cycle");
	a_issue_refuse: assert property (issue |-> !fetch_ready)
		else $error("word accepted during issue cycle");
endmodule : cidt_decoder_chk

bind cidt_decoder cidt_decoder_chk #(.CYC_BRANCH(CYC_BRANCH), .CYC_TABLE(CYC_TABLE), .CYC_RETURN(CYC_RETURN))
	u_chk (.clk(clk), .rstn(rstn), .fetch_valid(fetch_valid), .fetch_word(fetch_word), .fetch_ready(fetch_ready),
	.fetch_flush(fetch_flush), .dec(dec), .issue(issue), .bubble(bubble), .exec_taken(exec_taken));

// ==== cidt_fetch_model.sv ====
`timescale 1ns/1ps
module cidt_fetch_model (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// pacing
	input wire logic stall,
	// decoder fetch side
	output logic fetch_valid,
	output logic [23:0] fetch_word,
	input wire logic fetch_ready,
	input wire logic fetch_flush
);
	logic [23:0] words[$];
	logic held;

	initial
	begin
		fetch_valid = 1'b0;
		fetch_word = 24'h00_0000;
	end

	// an offered word stays until taken or flushed; idle data toggles so stale values never look valid
	always @(posedge clk)
	begin
		held = fetch_valid && !fetch_ready && !fetch_flush;
		if (rstn && ((fetch_valid && fetch_ready) || fetch_flush) && words.size() > 0)
			void'(words.pop_front());
		if (!rstn || !held)
		begin
			fetch_valid <= rstn && !stall && words.size() > 0;
			fetch_word <= (rstn && !stall && words.size() > 0) ? words[0] : ~fetch_word;
		end
	end
endmodule : cidt_fetch_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	logic clk, rstn, stall, exec_taken, fetch_valid, fetch_ready, fetch_flush, issue, bubble;
	logic [23:0] fetch_word, w;
	logic [31:0] r;
	logic [7:0] op;
	cidt_pkg::cidt_dec_t dec;
	logic [23:0] prog[$];
	logic [7:0] ops[16] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
		8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h7e, 8'h00, 8'h0e};
	int miscompares = 0, compares = 0, idx = 0, nb = 0, nf = 0, exp_b = 0, exp_f = 0, n = 0;
	int seed = 32'h3aeb;

	cidt_decoder uut (.clk(clk), .rstn(rstn), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
		.fetch_ready(fetch_ready), .fetch_flush(fetch_flush), .dec(dec), .issue(issue), .bubble(bubble),
		.exec_taken(exec_taken));
	cidt_fetch_model u_fetch (.clk(clk), .rstn(rstn), .stall(stall), .fetch_valid(fetch_valid),
		.fetch_word(fetch_word), .fetch_ready(fetch_ready), .fetch_flush(fetch_flush));

	// extra cycles per opcode with the default counts 2, 2, 3
	function automatic int extra(logic [7:0] o, logic tk);
		if (o inside {[8'h01:8'h06], [8'h0a:8'h0c], 8'h7e})
			return 1;
		if (o inside {8'h07, 8'h08})
			return 2;
		return (o == 8'h09) ? int'(tk) : 0;
	endfunction : extra

	// program counter moves, so the prefetched word is lost
	function automatic int redirect(logic [7:0] o, logic tk);
		return int'(o inside {[8'h01:8'h04], 8'h07, 8'h08, 8'h0a, 8'h0b} || (o == 8'h09 && tk));
	endfunction : redirect

	function automatic int pair(logic [7:0] o);
		return int'(o inside {[8'h0a:8'h0c]});
	endfunction : pair

	task automatic chk(input bit ok, input string msg);
		compares++;
		if (!ok)
		begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk

	task automatic load(input logic [23:0] wd);
		prog.push_back(wd);
		u_fetch.words.push_back(wd);
	endtask : load

	task automatic wrap_up();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// random pacing and condition outcomes
	always @(posedge clk)
	begin
		stall <= ($random(seed) & 3) == 0;
		exec_taken <= 1'($random(seed));
	end

	// at each issue score the cycles of the one before, then the issue against the program
	always @(posedge clk)
	begin
		if (rstn && bubble)
			nb++;
		if (rstn && fetch_flush)
			nf++;
		if (rstn && issue)
		begin
			chk(nb == exp_b, "added cycle count");
			chk(nf == exp_f, "flush count");
			w = prog[idx];
			chk(dec.opcode === w[23:16], "opcode");
			if (w[23:16] inside {8'h0a, 8'h0b})
				chk(dec.prog_addr === {prog[idx + 1][6:0], w[15:0]}, "long address");
			if (w[23:22] == 2'b01)
				chk(w[17] ? dec.file_addr === w[12:0] : dec.first_source_register === w[15:12], "operands");
			if (w[23:21] == 3'b111)
				chk(dec.result_register === (w[9] ? w[13:10] : w[3:0]), "literal result");
			if (w[23:16] == 8'h0c)
				chk(dec.literal === {prog[idx + 1][7:0], w[11:4]}, "long move literal");
			if (w[23:22] == 2'b10)
				chk(dec.bit_number === w[3:0], "bit number");
			if (w[23:21] == 3'b110)
				chk(dec.literal === (w[17] ? {8'h00, w[7:0]} : {4'h0, w[15:4]}), "literal move");
			chk(dec.op_class === cidt_pkg::cidt_class_t'(w[23:22]), "operand class");
			idx += 1 + pair(w[23:16]);
			exp_b = extra(w[23:16], exec_taken);
			exp_f = redirect(w[23:16], exec_taken);
			idx += exp_f;
			if (w[23:16] == 8'h0d && exec_taken)
			begin
				exp_b = 1 + pair(prog[idx][23:16]);
				idx += exp_b;
			end
			nb = 0;
			nf = 0;
		end
	end

	initial
	begin
		rstn = 1'b0;
		// corners: lone second word, jump, skip over a pair, double move, table, return
		load(24'h00_1234);
		load(24'h01_0000);
		load(24'h40_0000);
		load(24'h0d_0000);
		load(24'h0a_5678);
		load(24'h00_0012);
		load(24'h7e_0000);
		load(24'h05_0000);
		load(24'h08_0000);
		repeat (400)
		begin
			r = $random(seed);
			op = (r[31:28] < 4'h6) ? ops[r[27:24]] : r[23:16];
			load({op, r[15:0]});
			if (pair(op) == 1)
				load({8'h00, 16'($random(seed))});
		end
		repeat (4)
			load(24'h40_0000);
		repeat (3)
			@(posedge clk);
		rstn <= 1'b1;
		while (idx < prog.size() - 4 && n < 20000)
		begin
			@(posedge clk);
			n++;
		end
		// a stalled program must not slip through to the verdict
		if (idx < prog.size() - 4)
		begin
			miscompares++;
			$display("[FAIL] %0t program did not complete", $time);
		end
		repeat (10)
			@(posedge clk);
		wrap_up();
	end

	// hang guard: the program needs well under 6000 cycles
	initial
	begin
		#100000;
		miscompares++;
		$display("[FAIL] %0t watchdog expired", $time);
		wrap_up();
	end
endmodule : tb_top
